/* File: rtl/mrad_top.sv */
// memory region attribute decoder with barrier and ordering control
// Notes on behaviour
// - below sram base: code region, normal, executable, data allowed
// - from sram base: normal executable memory for data or code
// - from peripheral base: device memory, execute never
// - external ram normal; low half write-back allocate, high write-through
// - external device execute never; first half shareable, second not
// - private peripheral bus strongly-ordered, shareable, execute never
// - above private bus: vendor device memory, execute never
// - reordering only where sequence behaviour stays unchanged
// - data order barrier drains outstanding before later memory issue
// - data sync barrier drains outstanding before later instructions run
// - instruction sync barrier makes completed effects visible afterwards
// - strongly-ordered accesses ordered by hardware without barriers
// - fetch from execute-never region blocked, raises memory fault
// - device same-share and strongly-ordered pairs observed in order
module mrad_top (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_addr,
  input wire logic i_fetch,
  input wire logic i_req_valid,
  input wire logic i_resp_done,
  input wire mrad_pkg::mrad_barrier_t i_barrier,
  output mrad_pkg::mrad_region_t o_region,
  output mrad_pkg::mrad_memtype_t o_mem_type,
  output logic o_execute_never,
  output logic o_shareable,
  output mrad_pkg::mrad_cache_t o_cache_policy,
  output logic o_req_ready,
  output logic o_issue,
  output logic o_fetch_block,
  output logic o_mm_fault,
  output logic o_exec_hold,
  output logic o_pipe_flush,
  output logic o_barrier_done
);

  // ----------------------------------------------------------------
  // attribute decode
  // ----------------------------------------------------------------
  logic dec_strong;
  logic dec_device;

  mrad_decode u_decode (
    .i_addr(i_addr),
    .o_region(o_region),
    .o_mem_type(o_mem_type),
    .o_execute_never(o_execute_never),
    .o_shareable(o_shareable),
    .o_cache_policy(o_cache_policy)
  );

  assign dec_strong = (o_mem_type == mrad_pkg::MRAD_MT_STRONG);
  assign dec_device = (o_mem_type == mrad_pkg::MRAD_MT_DEVICE);

  // ----------------------------------------------------------------
  // ordering state
  // ----------------------------------------------------------------
  mrad_pkg::mrad_state_t st_r;
  mrad_pkg::mrad_state_t st_nxt;
  logic [mrad_pkg::OUTST_W-1:0] outst_r;
  logic [mrad_pkg::OUTST_W-1:0] outst_nxt;
  logic sync_r;
  logic sync_nxt;
  logic [1:0] flush_cnt_r;
  logic [1:0] flush_cnt_nxt;
  logic last_ord_r;
  logic last_ord_nxt;
  logic last_share_r;
  logic last_share_nxt;
  logic fault_r;
  logic fault_nxt;
  logic done_r;
  logic done_nxt;
  logic need_order;
  logic ord_block;
  logic fetch_noexec;
  logic data_ok;

  // device after device of matching share or after a shareable one, or any strong pairing, must
  // wait for the earlier one; normal accesses pass freely
  always_comb begin
    need_order = 1'b0;
    if (last_ord_r && (dec_strong || dec_device)) begin
      need_order = dec_strong || last_share_r == o_shareable ||
                   last_share_r;
    end
  end

  // strongly-ordered needs no barrier: it waits for the queue only behind a device or strong access
  assign ord_block = need_order && (outst_r != '0);
  assign fetch_noexec = i_fetch && o_execute_never;
  // normal accesses overlap freely; outstanding cap bounds reordering
  assign data_ok = (st_r == mrad_pkg::MRAD_ST_IDLE) && !ord_block &&
                   (outst_r != mrad_pkg::OUTST_MAX);
  assign o_req_ready = data_ok && !fetch_noexec;
  assign o_issue = i_req_valid && o_req_ready;
  assign o_fetch_block = fetch_noexec;
  assign o_mm_fault = fault_r;
  assign o_exec_hold = (st_r != mrad_pkg::MRAD_ST_IDLE) && sync_r;
  assign o_pipe_flush = (st_r == mrad_pkg::MRAD_ST_FLUSH);
  assign o_barrier_done = done_r;

  always_comb begin
    st_nxt = st_r;
    sync_nxt = sync_r;
    flush_cnt_nxt = flush_cnt_r;
    done_nxt = 1'b0;
    fault_nxt = i_req_valid && fetch_noexec;
    outst_nxt = outst_r;
    last_ord_nxt = last_ord_r;
    last_share_nxt = last_share_r;
    if (o_issue) begin
      last_ord_nxt = dec_strong || dec_device;
      last_share_nxt = o_shareable;
    end
    if (o_issue && !i_resp_done) begin
      outst_nxt = outst_r + 1'b1;
    end else if (!o_issue && i_resp_done && outst_r != '0) begin
      outst_nxt = outst_r - 1'b1;
    end
    case (st_r)
      mrad_pkg::MRAD_ST_IDLE: begin
        if (i_barrier == mrad_pkg::MRAD_BAR_ORDER ||
            i_barrier == mrad_pkg::MRAD_BAR_SYNC) begin
          st_nxt = mrad_pkg::MRAD_ST_DRAIN;
          sync_nxt = (i_barrier == mrad_pkg::MRAD_BAR_SYNC);
        end else if (i_barrier == mrad_pkg::MRAD_BAR_INSTR) begin
          st_nxt = mrad_pkg::MRAD_ST_FLUSH;
          flush_cnt_nxt = mrad_pkg::INSTR_FLUSH_CYC;
        end
      end
      mrad_pkg::MRAD_ST_DRAIN: begin
        if (outst_r == '0 || (outst_r == 4'h1 && i_resp_done)) begin
          st_nxt = mrad_pkg::MRAD_ST_IDLE;
          sync_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      mrad_pkg::MRAD_ST_FLUSH: begin
        if (flush_cnt_r == 2'h1) begin
          st_nxt = mrad_pkg::MRAD_ST_IDLE;
          done_nxt = 1'b1;
        end
        flush_cnt_nxt = flush_cnt_r - 2'h1;
      end
      default: begin
        st_nxt = mrad_pkg::MRAD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= mrad_pkg::MRAD_ST_IDLE;
      outst_r <= '0;
      sync_r <= 1'b0;
      flush_cnt_r <= 2'h0;
      last_ord_r <= 1'b0;
      last_share_r <= 1'b0;
      fault_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      outst_r <= outst_nxt;
      sync_r <= sync_nxt;
      flush_cnt_r <= flush_cnt_nxt;
      last_ord_r <= last_ord_nxt;
      last_share_r <= last_share_nxt;
      fault_r <= fault_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ppb_attrs: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_addr >= mrad_pkg::PPB_BASE && i_addr < mrad_pkg::VEND_BASE) |->
    (dec_strong && o_shareable && o_execute_never))
    else $error("private bus attributes wrong");

  a_xram_policy: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (o_region == mrad_pkg::MRAD_RG_XRAM) |->
    (o_cache_policy == (i_addr[29] ? mrad_pkg::MRAD_CP_WBAL :
                        mrad_pkg::MRAD_CP_WTHR)))
    else $error("external ram policy wrong");

  a_xdev_share: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (o_region == mrad_pkg::MRAD_RG_XDEV) |->
    (o_shareable == !i_addr[30] && o_execute_never))
    else $error("external device share wrong");

  a_low_exec: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_addr < mrad_pkg::PERI_BASE) |->
    (!o_execute_never && o_mem_type == mrad_pkg::MRAD_MT_NORMAL))
    else $error("code or sram not executable");

  a_peri_dev: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_addr[31:29] == 3'h2) |-> (dec_device && o_execute_never))
    else $error("peripheral attributes wrong");

  a_vend_dev: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_addr >= mrad_pkg::VEND_BASE) |->
    (dec_device && !o_shareable && o_execute_never))
    else $error("vendor region attributes wrong");

  a_noexec_fault: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_fetch && i_req_valid && o_execute_never) |->
    (!o_issue ##1 o_mm_fault))
    else $error("execute never fetch not faulted");

  a_order_drain: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (st_r == mrad_pkg::MRAD_ST_DRAIN) |-> !o_issue)
    else $error("issue during barrier drain");

  a_sync_hold: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (st_r == mrad_pkg::MRAD_ST_IDLE && i_barrier == mrad_pkg::MRAD_BAR_SYNC)
    |=> o_exec_hold)
    else $error("sync barrier did not hold");

  a_instr_flush: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (st_r == mrad_pkg::MRAD_ST_IDLE && i_barrier == mrad_pkg::MRAD_BAR_INSTR)
    |=> o_pipe_flush ##1 o_barrier_done)
    else $error("instruction barrier flush wrong");

  a_strong_wait: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (o_issue && dec_strong) |-> (outst_r == '0 || !last_ord_r))
    else $error("strong access overtook ordered");

endmodule

/* File: rtl/mrad_pkg.sv */
// package: region bases, attribute encodings and barrier types
package mrad_pkg;

  typedef enum logic [1:0] {
    MRAD_MT_NORMAL = 2'h0,
    MRAD_MT_DEVICE = 2'h1,
    MRAD_MT_STRONG = 2'h2
  } mrad_memtype_t;

  typedef enum logic [1:0] {
    MRAD_CP_NONE = 2'h0,
    MRAD_CP_WBAL = 2'h1,
    MRAD_CP_WTHR = 2'h2
  } mrad_cache_t;

  typedef enum logic [2:0] {
    MRAD_RG_CODE = 3'h0,
    MRAD_RG_SRAM = 3'h1,
    MRAD_RG_PERI = 3'h2,
    MRAD_RG_XRAM = 3'h3,
    MRAD_RG_XDEV = 3'h4,
    MRAD_RG_PPB  = 3'h5,
    MRAD_RG_VEND = 3'h6
  } mrad_region_t;

  typedef enum logic [1:0] {
    MRAD_BAR_NONE = 2'h0,
    MRAD_BAR_ORDER = 2'h1,
    MRAD_BAR_SYNC = 2'h2,
    MRAD_BAR_INSTR = 2'h3
  } mrad_barrier_t;

  // barrier engine states: each busy state sits one bit away from idle
  typedef enum logic [1:0] {
    MRAD_ST_IDLE = 2'h0,
    MRAD_ST_DRAIN = 2'h1,
    MRAD_ST_FLUSH = 2'h2
  } mrad_state_t;

  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] PERI_BASE = 32'h4000_0000;
  localparam logic [31:0] XRAM_BASE = 32'h6000_0000;
  localparam logic [31:0] XRAM_WTHR_BASE = 32'h8000_0000;
  localparam logic [31:0] XDEV_BASE = 32'ha000_0000;
  localparam logic [31:0] XDEV_NS_BASE = 32'hc000_0000;
  localparam logic [31:0] PPB_BASE = 32'he000_0000;
  localparam logic [31:0] VEND_BASE = 32'he010_0000;

  localparam int OUTST_W = 4;
  localparam logic [3:0] OUTST_MAX = 4'hf;
  localparam logic [1:0] INSTR_FLUSH_CYC = 2'h1;

endpackage

/* File: rtl/mrad_decode.sv */
// combinational address to region attribute decode
module mrad_decode (
  input wire logic [31:0] i_addr,
  output mrad_pkg::mrad_region_t o_region,
  output mrad_pkg::mrad_memtype_t o_mem_type,
  output logic o_execute_never,
  output logic o_shareable,
  output mrad_pkg::mrad_cache_t o_cache_policy
);

  always_comb begin
    o_region = mrad_pkg::MRAD_RG_CODE;
    o_mem_type = mrad_pkg::MRAD_MT_NORMAL;
    o_execute_never = 1'b0;
    o_shareable = 1'b0;
    o_cache_policy = mrad_pkg::MRAD_CP_NONE;
    if (i_addr >= mrad_pkg::VEND_BASE) begin
      o_region = mrad_pkg::MRAD_RG_VEND;
      o_mem_type = mrad_pkg::MRAD_MT_DEVICE;
      o_execute_never = 1'b1;
    end else if (i_addr >= mrad_pkg::PPB_BASE) begin
      o_region = mrad_pkg::MRAD_RG_PPB;
      o_mem_type = mrad_pkg::MRAD_MT_STRONG;
      o_execute_never = 1'b1;
      o_shareable = 1'b1;
    end else if (i_addr >= mrad_pkg::XDEV_BASE) begin
      o_region = mrad_pkg::MRAD_RG_XDEV;
      o_mem_type = mrad_pkg::MRAD_MT_DEVICE;
      o_execute_never = 1'b1;
      o_shareable = (i_addr < mrad_pkg::XDEV_NS_BASE);
    end else if (i_addr >= mrad_pkg::XRAM_BASE) begin
      o_region = mrad_pkg::MRAD_RG_XRAM;
      o_cache_policy = (i_addr < mrad_pkg::XRAM_WTHR_BASE) ?
          mrad_pkg::MRAD_CP_WBAL : mrad_pkg::MRAD_CP_WTHR;
    end else if (i_addr >= mrad_pkg::PERI_BASE) begin
      o_region = mrad_pkg::MRAD_RG_PERI;
      o_mem_type = mrad_pkg::MRAD_MT_DEVICE;
      o_execute_never = 1'b1;
    end else if (i_addr >= mrad_pkg::SRAM_BASE) begin
      o_region = mrad_pkg::MRAD_RG_SRAM;
    end else begin
      o_region = mrad_pkg::MRAD_RG_CODE;
    end
  end

endmodule

/* File: tb/mrad_core_model.sv */
// core-side completion model: answers each issued access in order
module mrad_core_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_issue,
  input wire logic i_stall,
  output logic o_resp_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int pend;
  int left;
  // one completion a cycle at most; stall stands for a slow slave
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend <= 0;
      o_resp_done <= 1'b0;
    end else begin
      left = pend + int'(i_issue) - int'(o_resp_done);
      pend <= left;
      o_resp_done <= #1 (left != 0) && !i_stall;
    end
  end
endmodule

/* File: tb/mrad_top_bench.sv */
// self-checking bench for the region decoder and barrier engine
module mrad_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic fetch = 1'b0;
  logic valid = 1'b0;
  logic stall = 1'b0;
  logic done_in;
  mrad_pkg::mrad_barrier_t bar = mrad_pkg::MRAD_BAR_NONE;
  mrad_pkg::mrad_region_t o_region;
  mrad_pkg::mrad_memtype_t o_mem_type;
  mrad_pkg::mrad_cache_t o_cache_policy;
  logic o_execute_never, o_shareable, o_req_ready, o_issue, o_fetch_block;
  logic o_mm_fault, o_exec_hold, o_pipe_flush, o_barrier_done;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  mrad_top mrad_top_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_fetch(fetch), .i_req_valid(valid), .i_resp_done(done_in),
    .i_barrier(bar), .o_region(o_region), .o_mem_type(o_mem_type),
    .o_execute_never(o_execute_never), .o_shareable(o_shareable),
    .o_cache_policy(o_cache_policy), .o_req_ready(o_req_ready),
    .o_issue(o_issue), .o_fetch_block(o_fetch_block),
    .o_mm_fault(o_mm_fault), .o_exec_hold(o_exec_hold),
    .o_pipe_flush(o_pipe_flush), .o_barrier_done(o_barrier_done));

  mrad_core_model mrad_core_model_inst (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_issue(o_issue), .i_stall(stall), .o_resp_done(done_in));

  task close_out;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hung handshake must still reach the report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      close_out;
    end
  end

  task tick;
    @(posedge clk);
    #1;
  endtask

  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // decode is combinational: judged a step after the address, one a cycle
  task dec(input logic [31:0] a, input mrad_pkg::mrad_region_t rg,
           input mrad_pkg::mrad_memtype_t mt, input logic no_ex,
           input logic sh, input mrad_pkg::mrad_cache_t cp);
    addr = a;
    #1;
    chk(o_region === rg && o_mem_type === mt, "region or type");
    chk(o_execute_never === no_ex && o_shareable === sh,
        "never or share");
    chk(o_cache_policy === cp, "cache policy");
    tick;
  endtask

  task wait_done;
    int k;
    k = 0;
    while (o_barrier_done !== 1'b1 && k < 20) begin
      tick;
      k++;
    end
    chk(o_barrier_done === 1'b1, "barrier never completed");
  endtask

  // one access left outstanding with a stalled slave, then a barrier
  task drain(input mrad_pkg::mrad_barrier_t b);
    stall = 1'b1;
    addr = mrad_pkg::SRAM_BASE;
    valid = 1'b1;
    tick;
    valid = 1'b0;
    bar = b;
    tick;
    bar = mrad_pkg::MRAD_BAR_NONE;
    valid = 1'b1;
    repeat (3) begin
      chk(o_req_ready === 1'b0 && o_issue === 1'b0, "passed barrier");
      chk(o_exec_hold === (b == mrad_pkg::MRAD_BAR_SYNC), "exec hold");
      chk(o_barrier_done === 1'b0, "done before drain");
      tick;
    end
    valid = 1'b0;
    stall = 1'b0;
    wait_done;
    chk(o_req_ready === 1'b1 && o_exec_hold === 1'b0, "not released");
    tick;
  endtask

  task instr_flush;
    bar = mrad_pkg::MRAD_BAR_INSTR;
    tick;
    bar = mrad_pkg::MRAD_BAR_NONE;
    chk(o_pipe_flush === 1'b1 && o_req_ready === 1'b0, "no flush");
    tick;
    chk(o_barrier_done === 1'b1 && o_pipe_flush === 1'b0, "flush end");
    tick;
    chk(o_barrier_done === 1'b0, "done longer than one cycle");
  endtask

  task noexec_fetch;
    addr = mrad_pkg::PERI_BASE;
    fetch = 1'b1;
    valid = 1'b1;
    #1;
    chk(o_fetch_block === 1'b1 && o_issue === 1'b0, "fetch issued");
    tick;
    valid = 1'b0;
    chk(o_mm_fault === 1'b1, "no fault");
    addr = 32'h0000_0100;
    valid = 1'b1;
    #1;
    chk(o_fetch_block === 1'b0 && o_issue === 1'b1, "code fetch held");
    tick;
    valid = 1'b0;
    fetch = 1'b0;
    chk(o_mm_fault === 1'b0, "fault without cause");
    repeat (4) tick;
  endtask

  // one address a cycle, driven after the edge; valid stays low, so nothing issues meanwhile
  task probe(input logic [31:0] a, input logic rdy, input string m);
    addr = a;
    #1;
    chk(o_req_ready === rdy, m);
    tick;
  endtask

  // one nonshareable device access held outstanding by a stalled slave
  task dev_order;
    stall = 1'b1;
    addr = mrad_pkg::PERI_BASE;
    valid = 1'b1;
    tick;
    valid = 1'b0;
    probe(mrad_pkg::XDEV_NS_BASE, 1'b0, "device passed device");
    probe(mrad_pkg::PPB_BASE, 1'b0, "strong passed device");
    probe(mrad_pkg::XDEV_BASE, 1'b1, "shareable device held");
    probe(mrad_pkg::SRAM_BASE, 1'b1, "normal access held");
    stall = 1'b0;
    repeat (4) tick;
    // a strong access on an empty queue issues, then holds a device one
    addr = mrad_pkg::PPB_BASE;
    valid = 1'b1;
    #1;
    chk(o_issue === 1'b1, "strong held on empty queue");
    tick;
    valid = 1'b0;
    probe(mrad_pkg::PERI_BASE, 1'b0, "device passed strong");
    repeat (4) tick;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    tick;
    dec(32'h1fff_ffff, mrad_pkg::MRAD_RG_CODE, mrad_pkg::MRAD_MT_NORMAL,
        1'b0, 1'b0, mrad_pkg::MRAD_CP_NONE);
    dec(32'h2000_0000, mrad_pkg::MRAD_RG_SRAM, mrad_pkg::MRAD_MT_NORMAL,
        1'b0, 1'b0, mrad_pkg::MRAD_CP_NONE);
    dec(32'h4000_0000, mrad_pkg::MRAD_RG_PERI, mrad_pkg::MRAD_MT_DEVICE,
        1'b1, 1'b0, mrad_pkg::MRAD_CP_NONE);
    dec(32'h7fff_ffff, mrad_pkg::MRAD_RG_XRAM, mrad_pkg::MRAD_MT_NORMAL,
        1'b0, 1'b0, mrad_pkg::MRAD_CP_WBAL);
    dec(32'h8000_0000, mrad_pkg::MRAD_RG_XRAM, mrad_pkg::MRAD_MT_NORMAL,
        1'b0, 1'b0, mrad_pkg::MRAD_CP_WTHR);
    dec(32'hbfff_ffff, mrad_pkg::MRAD_RG_XDEV, mrad_pkg::MRAD_MT_DEVICE,
        1'b1, 1'b1, mrad_pkg::MRAD_CP_NONE);
    dec(32'hc000_0000, mrad_pkg::MRAD_RG_XDEV, mrad_pkg::MRAD_MT_DEVICE,
        1'b1, 1'b0, mrad_pkg::MRAD_CP_NONE);
    dec(32'he00f_ffff, mrad_pkg::MRAD_RG_PPB, mrad_pkg::MRAD_MT_STRONG,
        1'b1, 1'b1, mrad_pkg::MRAD_CP_NONE);
    dec(32'he010_0000, mrad_pkg::MRAD_RG_VEND, mrad_pkg::MRAD_MT_DEVICE,
        1'b1, 1'b0, mrad_pkg::MRAD_CP_NONE);
    noexec_fetch;
    dev_order;
    drain(mrad_pkg::MRAD_BAR_ORDER);
    drain(mrad_pkg::MRAD_BAR_SYNC);
    instr_flush;
    close_out;
  end
endmodule
